//--- src/dlt_defs.svh
// Register offsets, field positions, reset values and divider counts
`ifndef DLT_DEFS_SVH
`define DLT_DEFS_SVH
// ****************************
// Register offsets
// ****************************
`define DLT_ADDR_RUN_FLAG 8'h88
`define DLT_ADDR_MODE 8'h89
`define DLT_ADDR_A_LOW 8'h8a
`define DLT_ADDR_B_LOW 8'h8b
`define DLT_ADDR_A_HIGH 8'h8c
`define DLT_ADDR_B_HIGH 8'h8d
`define DLT_ADDR_CLK_SEL 8'h8e
`define DLT_REG_RESET 8'h00
// ****************************
// Field positions
// ****************************
`define DLT_CK_D_HIGH 7
`define DLT_CK_D_LOW 6
`define DLT_CK_C_HIGH 5
`define DLT_CK_C_LOW 4
`define DLT_CK_B_SYS 3
`define DLT_CK_A_SYS 2
`define DLT_CK_SCALE_LO 0
`define DLT_RF_B_FLAG 7
`define DLT_RF_B_RUN 6
`define DLT_RF_A_FLAG 5
`define DLT_RF_A_RUN 4
`define DLT_MD_B_GATE 7
`define DLT_MD_B_CNT 6
`define DLT_MD_B_MODE_LO 4
`define DLT_MD_A_GATE 3
`define DLT_MD_A_CNT 2
`define DLT_MD_A_MODE_LO 0
// ****************************
// Prescaler divide counts
// ****************************
`define DLT_DIV_BY_12 6'd12
`define DLT_DIV_BY_4 6'd4
`define DLT_DIV_BY_48 6'd48
`define DLT_DIV_EXT_BY_8 6'd8
`endif

//--- src/dlt_pkg.sv
// Types shared by the dual timer block
package dlt_pkg;
   // Mode field, codes follow declaration order 0..3
   typedef enum logic [1:0] {DLT_MODE_13, DLT_MODE_16, DLT_MODE_RELOAD,
      DLT_MODE_SPLIT} dlt_mode_type;
   // Shared prescale selection
   typedef enum logic [1:0] {DLT_DIV12, DLT_DIV4, DLT_DIV48,
      DLT_EXT8} dlt_scale_type;
   // Special function register write request
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } dlt_sfr_req_type;
   // Result of one count step
   typedef struct packed {
      logic [7:0] tl;
      logic [7:0] th;
      logic ovf;
   } dlt_step_type;
endpackage

//--- src/dlt_sync_edge.sv
// Two-stage synchronisers with edge detection for pin inputs
`timescale 1ns/100ps
module dlt_sync_edge import dlt_pkg::*; #(
   parameter int WIDTH = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] fall,
   output logic [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] s1_r, s2_r, s3_r; // First stage feeds s2 only
   logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt;

   // ****************************
   // Sampling
   // ****************************
   // Next values, frozen while ce is low
   always_comb begin
      s1_nxt = ce ? din : s1_r;
      s2_nxt = ce ? s1_r : s2_r;
      s3_nxt = ce ? s2_r : s3_r;
   end

   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   // Edges compare successive settled samples
   assign level = s2_r;
   assign fall = s3_r & ~s2_r;
   assign rise = ~s3_r & s2_r;
endmodule

//--- src/dlt_prescaler.sv
// Shared prescaler giving a one-cycle tick for timers A and B
`timescale 1ns/100ps
`include "dlt_defs.svh"
module dlt_prescaler import dlt_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input dlt_scale_type scale,
   input wire logic ext_rise,
   output logic tick
);
   logic [5:0] cnt_r; // Cycles or external edges seen
   logic [5:0] cnt_nxt;
   logic adv; // Counter advances this cycle
   logic [5:0] last; // Terminal count

   // Divider terminal count for a selection
   function automatic logic [5:0] div_last(dlt_scale_type s);
      case (s)
         DLT_DIV12: div_last = `DLT_DIV_BY_12 - 6'd1;
         DLT_DIV4: div_last = `DLT_DIV_BY_4 - 6'd1;
         DLT_DIV48: div_last = `DLT_DIV_BY_48 - 6'd1;
         default: div_last = `DLT_DIV_EXT_BY_8 - 6'd1;
      endcase
   endfunction

   // ****************************
   // Divider
   // ****************************
   // External mode counts synchronised rising edges only
   always_comb begin
      last = div_last(scale);
      adv = ce & ((scale == DLT_EXT8) ? ext_rise : 1'b1);
      tick = adv & (cnt_r >= last);
      cnt_nxt = cnt_r;
      if (adv) begin
         // A smaller divider chosen mid-count wraps at once
         cnt_nxt = (cnt_r >= last) ? 6'd0 : cnt_r + 6'd1;
      end
   end

   // Register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 6'd0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

//--- src/dlt_timer_top.sv
// Dual legacy timer with shared prescaler and clock select register
// How it works
// - Prescaler gives div 12, 4, 48, ext/8
// - Timer B sysclk bit, ignored when counting
// - Timer A sysclk bit, ignored when counting except by split high byte
// - Timer C byte ticks: sysclk or own
// - Timer D byte ticks: sysclk or own
// - Two 16-bit counts as byte registers
// - 13-bit mode uses high byte, low five
// - 13-bit wrap sets flag, may interrupt
// - Counter select counts falling input edges
// - Count when run and gate permits
// - Run bit never clears the count
// - Timer B mirrors A with own inputs
// - 16-bit mode wraps at full width
// - Reload mode copies high into low
// - Split low byte uses timer A controls
// - Split high byte runs on B run
// - Split: B no flag, still pulses
// - Timer B mode 3 stops it
// - Mode field: 13, 16, reload, split
// - Flags cleared by write or vector
`timescale 1ns/100ps
`include "dlt_defs.svh"
module dlt_timer_top import dlt_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input dlt_sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic count_input_a,
   input wire logic count_input_b,
   input wire logic ext_irq_a_input,
   input wire logic ext_irq_b_input,
   input wire logic ext_clk_in,
   input wire logic ext_irq_a_polarity,
   input wire logic ext_irq_b_polarity,
   input wire logic timer_a_irq_enable,
   input wire logic timer_b_irq_enable,
   input wire logic isr_ack_a,
   input wire logic isr_ack_b,
   input wire logic timer_c_alt_clock_select,
   input wire logic timer_d_alt_clock_select,
   output logic timer_a_irq,
   output logic timer_b_irq,
   output logic timer_b_ovf_pulse,
   output logic timer_c_low_tick,
   output logic timer_c_high_tick,
   output logic timer_d_low_tick,
   output logic timer_d_high_tick
);
   // ****************************
   // Reset release
   // ****************************
   logic [1:0] rst_sync_r; // Release chain
   logic rst_sync_n; // Reset used by the block
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_r[1];

   // ****************************
   // Pin synchronisers and prescaler
   // ****************************
   logic [4:0] pin_lvl, pin_fall, pin_rise;
   logic pre_tick; // Prescaled tick
   logic [7:0] clk_sel_r, run_flag_r, mode_r; // Control registers
   logic [7:0] tl_a_r, th_a_r, tl_b_r, th_b_r; // Count bytes

   // Bits: 0 count A, 1 count B, 2 irq A, 3 irq B, 4 ext clock
   dlt_sync_edge #(.WIDTH(5)) u_sync (
      .clk(ref_clk),
      .rst_n(rst_sync_n),
      .ce(ce),
      .din({ext_clk_in, ext_irq_b_input, ext_irq_a_input,
            count_input_b, count_input_a}),
      .level(pin_lvl),
      .fall(pin_fall),
      .rise(pin_rise)
   );

   dlt_prescaler u_pre (
      .clk(ref_clk),
      .rst_n(rst_sync_n),
      .ce(ce),
      .scale(dlt_scale_type'(clk_sel_r[`DLT_CK_SCALE_LO +: 2])),
      .ext_rise(pin_rise[4]),
      .tick(pre_tick)
   );

   // One count step in modes 0..2, or the split low byte
   function automatic dlt_step_type step(dlt_mode_type m, logic [7:0] tl,
         logic [7:0] th);
      logic [12:0] c13;
      logic [15:0] c16;
      step.tl = tl;
      step.th = th;
      step.ovf = 1'b0;
      c13 = {th, tl[4:0]} + 13'd1;
      c16 = {th, tl} + 16'd1;
      case (m)
         DLT_MODE_13: begin
            // Upper three low-byte bits are left alone
            step.th = c13[12:5];
            step.tl = {tl[7:5], c13[4:0]};
            step.ovf = (c13 == 13'd0);
         end
         DLT_MODE_16: begin
            step.th = c16[15:8];
            step.tl = c16[7:0];
            step.ovf = (c16 == 16'd0);
         end
         default: begin
            // Reload copies high byte, split low byte just wraps
            step.ovf = (tl == 8'hff);
            step.tl = tl + 8'd1;
            if (step.ovf && m == DLT_MODE_RELOAD) begin
               step.tl = th;
            end
         end
      endcase
   endfunction

   // Gate check: active level follows the polarity setting
   function automatic logic gate_ok(logic gate, logic lvl, logic pol);
      gate_ok = !gate || (lvl == pol);
   endfunction

   // ****************************
   // Tick and run selection
   // ****************************
   dlt_mode_type mode_a, mode_b; // Decoded mode fields
   logic split; // Timer A in split mode
   logic time_tick_a, time_tick_b; // Timer ticks before counter select
   logic run_a, run_b, cnt_a, cnt_b; // Enables for this cycle
   logic run_hi; // Split high byte enable
   always_comb begin
      mode_a = dlt_mode_type'(mode_r[`DLT_MD_A_MODE_LO +: 2]);
      mode_b = dlt_mode_type'(mode_r[`DLT_MD_B_MODE_LO +: 2]);
      split = (mode_a == DLT_MODE_SPLIT);
      time_tick_a = clk_sel_r[`DLT_CK_A_SYS] | pre_tick;
      time_tick_b = clk_sel_r[`DLT_CK_B_SYS] | pre_tick;
      // Run bit and gate only enable, they never load the count
      run_a = run_flag_r[`DLT_RF_A_RUN]
         & gate_ok(mode_r[`DLT_MD_A_GATE], pin_lvl[2],
         ext_irq_a_polarity);
      cnt_a = ce & run_a
         & (mode_r[`DLT_MD_A_CNT] ? pin_fall[0] : time_tick_a);
      run_hi = ce & split & run_flag_r[`DLT_RF_B_RUN] & time_tick_a;
      // In split, B runs without its run bit but still under its gate, and never counts pins
      run_b = (mode_b != DLT_MODE_SPLIT)
         & (split | run_flag_r[`DLT_RF_B_RUN])
         & gate_ok(mode_r[`DLT_MD_B_GATE], pin_lvl[3],
         ext_irq_b_polarity);
      cnt_b = ce & run_b & ((mode_r[`DLT_MD_B_CNT] && !split) ?
         pin_fall[1] : time_tick_b);
   end

   // ****************************
   // Counts and flags
   // ****************************
   logic [7:0] tl_a_nxt, th_a_nxt, tl_b_nxt, th_b_nxt;
   logic [7:0] clk_sel_nxt, run_flag_nxt, mode_nxt;
   logic set_a, set_b, ovf_b; // Hardware flag events
   dlt_step_type sa, sb; // Step results
   logic [8:0] hi_a; // Split high byte plus carry
   logic wr_rf; // Run/flag register write
   always_comb begin
      sa = step(mode_a, tl_a_r, th_a_r);
      sb = step(mode_b, tl_b_r, th_b_r);
      hi_a = {1'b0, th_a_r} + 9'd1;
      tl_a_nxt = cnt_a ? sa.tl : tl_a_r;
      th_a_nxt = th_a_r;
      if (split) begin
         if (run_hi) begin
            th_a_nxt = hi_a[7:0];
         end
      end else if (cnt_a) begin
         th_a_nxt = sa.th;
      end
      tl_b_nxt = cnt_b ? sb.tl : tl_b_r;
      th_b_nxt = cnt_b ? sb.th : th_b_r;
      set_a = cnt_a & sa.ovf;
      ovf_b = cnt_b & sb.ovf;
      set_b = split ? (run_hi & hi_a[8]) : ovf_b;
      // Software writes take priority over counting
      clk_sel_nxt = clk_sel_r;
      mode_nxt = mode_r;
      wr_rf = ce & sfr_req.wr & (sfr_req.addr == `DLT_ADDR_RUN_FLAG);
      if (ce && sfr_req.wr) begin
         case (sfr_req.addr)
            `DLT_ADDR_CLK_SEL: clk_sel_nxt = sfr_req.wdata;
            `DLT_ADDR_MODE: mode_nxt = sfr_req.wdata;
            `DLT_ADDR_A_LOW: tl_a_nxt = sfr_req.wdata;
            `DLT_ADDR_A_HIGH: th_a_nxt = sfr_req.wdata;
            `DLT_ADDR_B_LOW: tl_b_nxt = sfr_req.wdata;
            `DLT_ADDR_B_HIGH: th_b_nxt = sfr_req.wdata;
            default: ;
         endcase
      end
      // Flags: a hardware set wins over a write or vector clear
      run_flag_nxt = run_flag_r;
      if (wr_rf) begin
         run_flag_nxt = {sfr_req.wdata[7:4], 4'h0};
      end else if (ce) begin
         run_flag_nxt[`DLT_RF_A_FLAG] = run_flag_r[`DLT_RF_A_FLAG]
            & ~isr_ack_a;
         run_flag_nxt[`DLT_RF_B_FLAG] = run_flag_r[`DLT_RF_B_FLAG]
            & ~isr_ack_b;
      end
      if (set_a) begin
         run_flag_nxt[`DLT_RF_A_FLAG] = 1'b1;
      end
      if (set_b) begin
         run_flag_nxt[`DLT_RF_B_FLAG] = 1'b1;
      end
   end

   // Registers, all zero after reset
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         clk_sel_r <= `DLT_REG_RESET;
         run_flag_r <= `DLT_REG_RESET;
         mode_r <= `DLT_REG_RESET;
         tl_a_r <= `DLT_REG_RESET;
         th_a_r <= `DLT_REG_RESET;
         tl_b_r <= `DLT_REG_RESET;
         th_b_r <= `DLT_REG_RESET;
      end else begin
         clk_sel_r <= clk_sel_nxt;
         run_flag_r <= run_flag_nxt;
         mode_r <= mode_nxt;
         tl_a_r <= tl_a_nxt;
         th_a_r <= th_a_nxt;
         tl_b_r <= tl_b_nxt;
         th_b_r <= th_b_nxt;
      end
   end

   // ****************************
   // Outputs
   // ****************************
   logic [7:0] rdata_nxt;
   logic [6:0] out_nxt, outs_r; // irq A, irq B, pulse, C lo/hi, D lo/hi
   // Read data follows the address one cycle later
   always_comb begin
      case (sfr_req.addr)
         `DLT_ADDR_CLK_SEL: rdata_nxt = clk_sel_r;
         `DLT_ADDR_RUN_FLAG: rdata_nxt = run_flag_r;
         `DLT_ADDR_MODE: rdata_nxt = mode_r;
         `DLT_ADDR_A_LOW: rdata_nxt = tl_a_r;
         `DLT_ADDR_A_HIGH: rdata_nxt = th_a_r;
         `DLT_ADDR_B_LOW: rdata_nxt = tl_b_r;
         `DLT_ADDR_B_HIGH: rdata_nxt = th_b_r;
         default: rdata_nxt = 8'h00;
      endcase
      if (!ce) begin
         rdata_nxt = sfr_rdata;
      end
      // Tick outputs are sysclk-wide enables when selected
      out_nxt = {run_flag_nxt[`DLT_RF_A_FLAG] & timer_a_irq_enable,
         run_flag_nxt[`DLT_RF_B_FLAG] & timer_b_irq_enable,
         ovf_b,
         clk_sel_r[`DLT_CK_C_LOW] | timer_c_alt_clock_select,
         clk_sel_r[`DLT_CK_C_HIGH] | timer_c_alt_clock_select,
         clk_sel_r[`DLT_CK_D_LOW] | timer_d_alt_clock_select,
         clk_sel_r[`DLT_CK_D_HIGH] | timer_d_alt_clock_select};
      // Frozen clock enable holds every output as it stood
      if (!ce) begin
         out_nxt = outs_r;
      end
   end

   // Output registers
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sfr_rdata <= 8'h00;
         outs_r <= 7'h00;
      end else begin
         sfr_rdata <= rdata_nxt;
         outs_r <= out_nxt;
      end
   end
   assign timer_a_irq = outs_r[6];
   assign timer_b_irq = outs_r[5];
   assign timer_b_ovf_pulse = outs_r[4];
   assign timer_c_low_tick = outs_r[3];
   assign timer_c_high_tick = outs_r[2];
   assign timer_d_low_tick = outs_r[1];
   assign timer_d_high_tick = outs_r[0];

   // ****************************
   // Checks
   // ****************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_sync_n);
   logic no_wr;
   assign no_wr = !sfr_req.wr;

   a_write_wins_a: assert property (ce && sfr_req.wr
      && sfr_req.addr == `DLT_ADDR_A_LOW |=> tl_a_r == $past(sfr_req.wdata))
      else $error("Low byte write lost to counting");
   a_reload_copy: assert property (cnt_a && no_wr && mode_a == DLT_MODE_RELOAD
      && tl_a_r == 8'hff |=> tl_a_r == $past(th_a_r)
      && th_a_r == $past(th_a_r) && run_flag_r[`DLT_RF_A_FLAG])
      else $error("Reload did not copy high byte");
   a_wrap_13bit: assert property (cnt_a && no_wr && mode_a == DLT_MODE_13
      && th_a_r == 8'hff && tl_a_r[4:0] == 5'h1f
      |=> th_a_r == 8'h00 && tl_a_r[4:0] == 5'h00
      && timer_a_irq == $past(timer_a_irq_enable))
      else $error("13-bit wrap missed flag or irq");
   a_count_16bit: assert property (cnt_a && no_wr && mode_a == DLT_MODE_16
      |=> {th_a_r, tl_a_r} == $past({th_a_r, tl_a_r}) + 16'd1)
      else $error("16-bit count did not step by one");
   a_gate_holds: assert property (ce && no_wr && mode_r[`DLT_MD_A_GATE]
      && pin_lvl[2] != ext_irq_a_polarity |=> $stable(tl_a_r))
      else $error("Gated timer counted");
   a_b_mode3_idle: assert property (no_wr && mode_b == DLT_MODE_SPLIT
      |=> $stable({th_b_r, tl_b_r}))
      else $error("Timer B counted in mode 3");
   a_split_no_flag: assert property (ce && no_wr && !isr_ack_b && split
      && !run_flag_r[`DLT_RF_B_FLAG] && !run_hi |=> !run_flag_r[`DLT_RF_B_FLAG])
      else $error("Timer B set its flag in split");
   a_flag_set_wins: assert property (set_a && isr_ack_a
      |=> run_flag_r[`DLT_RF_A_FLAG] && (timer_a_irq || !$past(timer_a_irq_enable)))
      else $error("Vector clear beat overflow");
   a_sys_tick_c: assert property (ce && clk_sel_r[`DLT_CK_C_LOW]
      |=> timer_c_low_tick)
      else $error("Timer C low tick not system clock");
endmodule

//--- bench/dlt_cpu_model.sv
// Partner model of the CPU core driving the timer register bus
`timescale 1ns/100ps
`include "dlt_defs.svh"
module dlt_cpu_model import dlt_pkg::*; (
   input wire logic ref_clk,
   output dlt_sfr_req_type sfr_req,
   input wire logic [7:0] sfr_rdata,
   output logic isr_ack_a,
   output logic isr_ack_b
);
   // ****************************
   // Bus cycles
   // ****************************
   // Idle bus at time zero so no stray write lands during reset
   initial begin
      sfr_req = '0;
      isr_ack_a = 1'b0;
      isr_ack_b = 1'b0;
   end
   // Write: request held over one edge, strobe dropped after it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= {a, 1'b1, d};
      @(posedge ref_clk);
      sfr_req.wr <= 1'b0;
   endtask
   // Read: data is registered, so it shows one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= {a, 1'b0, 8'h00};
      @(posedge ref_clk);
      #1 d = sfr_rdata;
   endtask
   // Start value goes in both bytes before any run bit is set
   task automatic load(input bit b, input logic [15:0] v);
      wr(b ? `DLT_ADDR_B_LOW : `DLT_ADDR_A_LOW, v[7:0]);
      wr(b ? `DLT_ADDR_B_HIGH : `DLT_ADDR_A_HIGH, v[15:8]);
   endtask
   // Vectoring to a service routine: one-cycle acknowledge
   task automatic vector(input bit b);
      @(posedge ref_clk);
      isr_ack_a <= ~b;
      isr_ack_b <= b;
      @(posedge ref_clk);
      isr_ack_a <= 1'b0;
      isr_ack_b <= 1'b0;
   endtask
endmodule

//--- bench/dual_legacy_timer_with_prescaler_bench.sv
// Self-checking bench for the dual legacy timer block
`timescale 1ns/100ps
`include "dlt_defs.svh"
module dual_legacy_timer_with_prescaler_bench import dlt_pkg::*; ;
   // ****************************
   // Stimulus and observed signals
   // ****************************
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic cin_a = 1'b1;
   logic cin_b = 1'b1;
   logic gate_a = 1'b0;
   logic gate_b = 1'b0;
   logic pol_a = 1'b1;
   logic pol_b = 1'b1;
   logic alt_c = 1'b0;
   logic alt_d = 1'b0;
   logic [1:0] ext_ph = 2'b00; // Ext clock phase, period of four cycles
   dlt_sfr_req_type req;
   logic [7:0] rdata;
   wire logic ack_a;
   wire logic ack_b;
   wire logic a_irq;
   wire logic b_irq;
   wire logic b_pulse;
   wire logic c_lo;
   wire logic c_hi;
   wire logic d_lo;
   wire logic d_hi;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   // Free-running clock
   always #25 ref_clk = ~ref_clk;
   // External prescaler clock, unrelated to gate windows
   always @(posedge ref_clk) ext_ph <= ext_ph + 2'd1;
   dlt_cpu_model cpu (.ref_clk(ref_clk), .sfr_req(req), .sfr_rdata(rdata),
      .isr_ack_a(ack_a), .isr_ack_b(ack_b));
   dlt_timer_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sfr_req(req),
      .sfr_rdata(rdata), .count_input_a(cin_a), .count_input_b(cin_b),
      .ext_irq_a_input(gate_a), .ext_irq_b_input(gate_b), .ext_clk_in(ext_ph[1]),
      .ext_irq_a_polarity(pol_a), .ext_irq_b_polarity(pol_b),
      .timer_a_irq_enable(1'b1), .timer_b_irq_enable(1'b1),
      .isr_ack_a(ack_a), .isr_ack_b(ack_b), .timer_c_alt_clock_select(alt_c),
      .timer_d_alt_clock_select(alt_d), .timer_a_irq(a_irq), .timer_b_irq(b_irq),
      .timer_b_ovf_pulse(b_pulse), .timer_c_low_tick(c_lo), .timer_c_high_tick(c_hi),
      .timer_d_low_tick(d_lo), .timer_d_high_tick(d_hi));
   // ****************************
   // Shared helpers
   // ****************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask
   // Read one register and compare it
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      cpu.rd(a, v);
      check(v, exp, what);
   endtask
   // Falling edges on a count pin, each level held three cycles
   task automatic edges(input bit b, input int n);
      repeat (n) begin
         if (b) cin_b <= 1'b0; else cin_a <= 1'b0;
         repeat (3) @(posedge ref_clk);
         if (b) cin_b <= 1'b1; else cin_a <= 1'b1;
         repeat (3) @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic stop_test();
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ****************************
   // Scenarios
   // ****************************
   // Reset values, unmapped place, read-only low run bits, byte access
   task automatic t_regs();
      for (int a = 8'h88; a <= 8'h8e; a++) begin
         rchk(a[7:0], `DLT_REG_RESET, "reset value");
      end
      cpu.wr(8'h90, 8'hff);
      rchk(8'h90, 8'h00, "unmapped read");
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h0f);
      rchk(`DLT_ADDR_RUN_FLAG, 8'h00, "low run bits");
      cpu.wr(`DLT_ADDR_CLK_SEL, 8'h5a);
      rchk(`DLT_ADDR_CLK_SEL, 8'h5a, "clock select rw");
      cpu.load(1'b0, 16'hc33c);
      rchk(`DLT_ADDR_A_LOW, 8'h3c, "low byte rw");
      rchk(`DLT_ADDR_A_HIGH, 8'hc3, "high byte rw");
   endtask
   // Gate open for 480 cycles; a multiple of every tick period
   task automatic rate(input bit b, input logic [7:0] ck, input logic [3:0] md,
         input logic pol, input logic [15:0] cnt);
      logic [7:0] lo;
      logic [7:0] hi;
      if (b) gate_b <= ~pol; else gate_a <= ~pol;
      if (b) pol_b <= pol; else pol_a <= pol;
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_CLK_SEL, ck);
      cpu.wr(`DLT_ADDR_MODE, b ? {md, 4'h0} : {4'h0, md});
      cpu.load(b, 16'h0005);
      cpu.wr(`DLT_ADDR_RUN_FLAG, b ? 8'h40 : 8'h10);
      // Long settle so a divider switch cannot skew the window
      repeat (60) @(posedge ref_clk);
      if (b) gate_b <= pol; else gate_a <= pol;
      repeat (480) @(posedge ref_clk);
      if (b) gate_b <= ~pol; else gate_a <= ~pol;
      repeat (8) @(posedge ref_clk);
      cpu.rd(b ? `DLT_ADDR_B_LOW : `DLT_ADDR_A_LOW, lo);
      cpu.rd(b ? `DLT_ADDR_B_HIGH : `DLT_ADDR_A_HIGH, hi);
      check({hi, lo}, 16'h0005 + cnt, "count over gate window");
   endtask
   // 13-bit, 16-bit and reload wraps counted on pin edges
   task automatic t_modes();
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_MODE, 8'h04);
      cpu.load(1'b0, 16'hff1e);
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h10);
      edges(1'b0, 2);
      rchk(`DLT_ADDR_A_HIGH, 8'h00, "13-bit high");
      rchk(`DLT_ADDR_A_LOW, 8'h00, "13-bit low");
      rchk(`DLT_ADDR_RUN_FLAG, 8'h30, "13-bit flag");
      check(a_irq, 1'b1, "timer a irq");
      cpu.vector(1'b0);
      rchk(`DLT_ADDR_RUN_FLAG, 8'h10, "flag after vector");
      check(a_irq, 1'b0, "irq after vector");
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_MODE, 8'h50);
      cpu.load(1'b1, 16'hffff);
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h40);
      edges(1'b1, 1);
      rchk(`DLT_ADDR_B_LOW, 8'h00, "16-bit low");
      rchk(`DLT_ADDR_B_HIGH, 8'h00, "16-bit high");
      rchk(`DLT_ADDR_RUN_FLAG, 8'hc0, "16-bit flag");
      check(b_irq, 1'b1, "timer b irq");
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h40);
      rchk(`DLT_ADDR_RUN_FLAG, 8'h40, "flag cleared by write");
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_MODE, 8'h06);
      cpu.load(1'b0, 16'h80fe);
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h10);
      edges(1'b0, 3);
      rchk(`DLT_ADDR_A_LOW, 8'h81, "reload low");
      rchk(`DLT_ADDR_A_HIGH, 8'h80, "reload high");
      rchk(`DLT_ADDR_RUN_FLAG, 8'h30, "reload flag");
      // Wrap lands in the very cycle of the vector acknowledge
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_CLK_SEL, 8'h04);
      cpu.wr(`DLT_ADDR_MODE, 8'h01);
      cpu.load(1'b0, 16'hfffe);
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h10);
      cpu.vector(1'b0);
      rchk(`DLT_ADDR_RUN_FLAG, 8'h30, "set beats vector clear");
   endtask
   // Split mode: low byte on pin, high byte on clock under timer B run
   task automatic t_split();
      bit seen;
      seen = 1'b0;
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_CLK_SEL, 8'h04);
      cpu.wr(`DLT_ADDR_MODE, 8'h37);
      cpu.load(1'b1, 16'h1234);
      cpu.load(1'b0, 16'h00ff);
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h10);
      edges(1'b0, 1);
      rchk(`DLT_ADDR_A_LOW, 8'h00, "split low wrap");
      rchk(`DLT_ADDR_A_HIGH, 8'h00, "split high idle");
      rchk(`DLT_ADDR_RUN_FLAG, 8'h30, "split low flag");
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h50);
      repeat (300) @(posedge ref_clk);
      rchk(`DLT_ADDR_RUN_FLAG, 8'hd0, "split high sets b flag");
      check(b_irq, 1'b1, "split high irq");
      rchk(`DLT_ADDR_B_LOW, 8'h34, "b inactive low");
      rchk(`DLT_ADDR_B_HIGH, 8'h12, "b inactive high");
      cpu.wr(`DLT_ADDR_RUN_FLAG, 8'h00);
      cpu.wr(`DLT_ADDR_CLK_SEL, 8'h0c);
      cpu.load(1'b1, 16'hfff0);
      cpu.wr(`DLT_ADDR_MODE, 8'h17);
      // Pulse lasts one cycle, so every edge is looked at
      for (int i = 0; i < 40; i++) begin
         @(posedge ref_clk);
         if (b_pulse === 1'b1) seen = 1'b1;
      end
      check(seen, 1'b1, "b overflow pulse in split");
      rchk(`DLT_ADDR_RUN_FLAG, 8'h00, "no b flag in split");
      cpu.wr(`DLT_ADDR_MODE, 8'h37);
   endtask
   // Tick steering for the timer C and D byte halves
   task automatic t_ticks();
      cpu.wr(`DLT_ADDR_CLK_SEL, 8'h50);
      repeat (3) @(posedge ref_clk);
      check({c_lo, c_hi, d_lo, d_hi}, 4'b1010, "low bytes on sysclk");
      alt_c <= 1'b1;
      alt_d <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check({c_lo, c_hi, d_lo, d_hi}, 4'b1111, "high bytes on own clock");
      cpu.wr(`DLT_ADDR_CLK_SEL, 8'ha0);
      alt_c <= 1'b0;
      alt_d <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check({c_lo, c_hi, d_lo, d_hi}, 4'b0101, "high bytes on sysclk");
   endtask
   // ****************************
   // Main sequence and hang guard
   // ****************************
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_regs();
      rate(1'b0, 8'h00, 4'h9, 1'b1, 16'd40);
      rate(1'b0, 8'h01, 4'h9, 1'b1, 16'd120);
      rate(1'b0, 8'h02, 4'h9, 1'b1, 16'd10);
      rate(1'b0, 8'h03, 4'h9, 1'b1, 16'd15);
      rate(1'b0, 8'h04, 4'h9, 1'b1, 16'd480);
      rate(1'b0, 8'h04, 4'hd, 1'b1, 16'd0);
      rate(1'b1, 8'h08, 4'h9, 1'b0, 16'd480);
      rate(1'b1, 8'h00, 4'h9, 1'b0, 16'd40);
      rate(1'b1, 8'h08, 4'hd, 1'b0, 16'd0);
      t_modes();
      t_split();
      t_ticks();
      stop_test();
   end
   // Runs need about 5700 cycles; well past that is a hang
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         stop_test();
      end
   end
endmodule
